// file: rtl/jnp_pkg.sv
// Constants, codes and state type of the test-port programming engine
package jnp_pkg;
  // ----------------------------------------------------------------
  // TAP controller states
  // ----------------------------------------------------------------
  typedef enum logic [15:0] {
    TAP_TLR = 16'h0001, TAP_RTI = 16'h0002, TAP_SEL_DR = 16'h0004, TAP_CAP_DR = 16'h0008,
    TAP_SH_DR = 16'h0010, TAP_EX1_DR = 16'h0020, TAP_PA_DR = 16'h0040, TAP_EX2_DR = 16'h0080,
    TAP_UP_DR = 16'h0100, TAP_SEL_IR = 16'h0200, TAP_CAP_IR = 16'h0400, TAP_SH_IR = 16'h0800,
    TAP_EX1_IR = 16'h1000, TAP_PA_IR = 16'h2000, TAP_EX2_IR = 16'h4000, TAP_UP_IR = 16'h8000
  } jnp_tap_t;

  // ----------------------------------------------------------------
  // Instruction codes and register widths
  // ----------------------------------------------------------------
  localparam logic [3:0] INSTR_ENABLE = 4'h4;
  localparam logic [3:0] INSTR_CMD = 4'h5;
  localparam logic [3:0] INSTR_PLOAD = 4'h6;
  localparam logic [3:0] INSTR_PREAD = 4'h7;
  localparam logic [3:0] INSTR_RESET = 4'hC;
  localparam logic [3:0] INSTR_BYPASS = 4'hF;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam int CMD_W = 15;
  localparam int EN_W = 16;
  localparam logic [15:0] UNLOCK_SIG = 16'hA370;
  localparam logic [15:0] EN_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Command prefixes (upper seven bits of the command word)
  // ----------------------------------------------------------------
  localparam logic [6:0] PFX_ADDR_LO = 7'h03;
  localparam logic [6:0] PFX_ADDR_HI = 7'h07;
  localparam logic [6:0] PFX_DATA_LO = 7'h13;
  localparam logic [6:0] PFX_DATA_HI = 7'h17;
  localparam logic [6:0] PFX_RD_LO = 7'h32;
  localparam logic [6:0] PFX_RD_HI = 7'h36;
  localparam logic [6:0] PFX_LATCH = 7'h77;
  localparam int STATUS_BIT = 9;

  // ----------------------------------------------------------------
  // Page buffer and timing
  // ----------------------------------------------------------------
  localparam int PAGE_AW = 6;
  localparam int PAGE_WORDS = 64;
  localparam int CLK_NS = 25;
  localparam int PL_WRITE_TCK = 11;
  localparam int RST_TO_NS0 = 100;
  localparam int RST_TO_NS1 = 1600;
  localparam int RST_TO_NS2 = 6400;
  localparam int RST_TO_NS3 = 25600;
  localparam logic [15:0] RST_TO_CYC0 = 16'((RST_TO_NS0 + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] RST_TO_CYC1 = 16'((RST_TO_NS1 + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] RST_TO_CYC2 = 16'((RST_TO_NS2 + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] RST_TO_CYC3 = 16'((RST_TO_NS3 + CLK_NS - 1) / CLK_NS);
endpackage : jnp_pkg

// file: rtl/jnp_mem_if.sv
// Write and read port between the engine and its page buffer
`timescale 1ns/10ps
interface jnp_mem_if;
  logic we;
  logic [1:0] be;
  logic [5:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport ctrl(output we, output be, output addr, output wdata, input rdata);
  modport store(input we, input be, input addr, input wdata, output rdata);
endinterface : jnp_mem_if

// file: rtl/jnp_page_mem.sv
// Page buffer with byte lanes and registered read data
`timescale 1ns/10ps
module jnp_page_mem (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  jnp_mem_if.store mem
);
  import jnp_pkg::*;

  genvar g;
  for (g = 0; g < 2; g++) begin : g_lane
    logic [7:0] arr_r [PAGE_WORDS];
    logic [7:0] rd_r;
    // Array itself carries no reset, so it maps onto plain RAM
    always_ff @(posedge clk_sys_i) begin
      if (mem.we && mem.be[g]) begin
        arr_r[mem.addr] <= mem.wdata[8*g +: 8];
      end
    end
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
        rd_r <= 8'h00;
      end else begin
        rd_r <= arr_r[mem.addr];
      end
    end
    assign mem.rdata[8*g +: 8] = rd_r;
  end
endmodule : jnp_page_mem

// file: rtl/jnp_tap.sv
// TAP controller state machine stepped by sampled test clock edges
`timescale 1ns/10ps
module jnp_tap (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic tck_rise_i,
  input wire logic tms_i,
  output jnp_pkg::jnp_tap_t state_o
);
  import jnp_pkg::*;

  jnp_tap_t state_r;
  jnp_tap_t state_nxt;

  always_comb begin
    state_nxt = state_r;
    if (tck_rise_i) begin
      case (state_r)
        TAP_TLR: state_nxt = tms_i ? TAP_TLR : TAP_RTI;
        TAP_RTI: state_nxt = tms_i ? TAP_SEL_DR : TAP_RTI;
        TAP_SEL_DR: state_nxt = tms_i ? TAP_SEL_IR : TAP_CAP_DR;
        TAP_CAP_DR: state_nxt = tms_i ? TAP_EX1_DR : TAP_SH_DR;
        TAP_SH_DR: state_nxt = tms_i ? TAP_EX1_DR : TAP_SH_DR;
        TAP_EX1_DR: state_nxt = tms_i ? TAP_UP_DR : TAP_PA_DR;
        TAP_PA_DR: state_nxt = tms_i ? TAP_EX2_DR : TAP_PA_DR;
        TAP_EX2_DR: state_nxt = tms_i ? TAP_UP_DR : TAP_SH_DR;
        TAP_UP_DR: state_nxt = tms_i ? TAP_SEL_DR : TAP_RTI;
        TAP_SEL_IR: state_nxt = tms_i ? TAP_TLR : TAP_CAP_IR;
        TAP_CAP_IR: state_nxt = tms_i ? TAP_EX1_IR : TAP_SH_IR;
        TAP_SH_IR: state_nxt = tms_i ? TAP_EX1_IR : TAP_SH_IR;
        TAP_EX1_IR: state_nxt = tms_i ? TAP_UP_IR : TAP_PA_IR;
        TAP_PA_IR: state_nxt = tms_i ? TAP_EX2_IR : TAP_PA_IR;
        TAP_EX2_IR: state_nxt = tms_i ? TAP_UP_IR : TAP_SH_IR;
        TAP_UP_IR: state_nxt = tms_i ? TAP_SEL_DR : TAP_RTI;
        default: state_nxt = TAP_TLR;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= TAP_TLR;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign state_o = state_r;
endmodule : jnp_tap

// file: rtl/jnp_top.sv
// Test-port programming engine: data registers, command path, page access
//
// How it works
// - Command instruction 0x5 puts the 15-bit command register on the scan path.
// - Capture-DR under command loads the previous command's result.
// - Shift-DR under command shifts out result, shifts in next command.
// - Update-DR under command presents the new word to memory control.
// - Entering Run-Test/Idle under command gives exactly one execute clock.
// - Page-load 0x6 uses the command register's low byte as data byte.
// - Page-load Update-DR copies byte to holding register, written within 11 TCK.
// - Page-load updates alternate low then high byte, low first.
// - Page-load pre-increments word address before each low byte but the first.
// - Page-read 0x7 captures memory byte each Capture-DR, low byte first.
// - Page-read post-increments word address after every high byte.
// - A one in the reset register holds the part in reset at once.
// - After the reset bit clears, reset stays for a clock-option time-out.
// - Programming is enabled only when the 16-bit register equals the signature.
// - Enable register clears on power-on reset; programmer clears it on leaving.
// - Flash read returns low byte, then high byte on the following shift.
// - All scan registers shift least significant bit first.
// - Instruction 0xC selects the one-bit reset register, TAP left alone.
// - Enable instruction 0x4 compares the signature on Update-DR.
`timescale 1ns/10ps
module jnp_top (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic nvm_ready_i,
  input wire logic [1:0] cksel_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  output logic part_reset_o,
  output logic prog_enabled_o,
  output logic [14:0] nvm_cmd_o,
  output logic nvm_exec_o
);
  import jnp_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic tck_s1_r, tck_s2_r, tck_s3_r, tms_s1_r, tms_s2_r, tdi_s1_r, tdi_s2_r;
  logic tck_rise, tck_fall;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      // Test clock idles high, so this value brings no false edge after release
      {tck_s1_r, tck_s2_r, tck_s3_r} <= 3'h7;
      {tms_s1_r, tms_s2_r, tdi_s1_r, tdi_s2_r} <= 4'hF;
    end else begin
      {tck_s1_r, tck_s2_r, tck_s3_r} <= {tck_i, tck_s1_r, tck_s2_r};
      {tms_s1_r, tms_s2_r} <= {tms_i, tms_s1_r};
      {tdi_s1_r, tdi_s2_r} <= {tdi_i, tdi_s1_r};
    end
  end

  // TMS and TDI share the clock's latency, so all three stay aligned
  assign tck_rise = tck_s2_r & ~tck_s3_r;
  assign tck_fall = ~tck_s2_r & tck_s3_r;

  jnp_tap_t tap_st;

  jnp_tap u_tap (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .tck_rise_i(tck_rise),
    .tms_i(tms_s2_r),
    .state_o(tap_st)
  );

  jnp_mem_if mem_if ();

  jnp_page_mem u_mem (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .mem(mem_if.store)
  );

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] to_cycles(input logic [1:0] sel);
    case (sel)
      2'h0: to_cycles = RST_TO_CYC0;
      2'h1: to_cycles = RST_TO_CYC1;
      2'h2: to_cycles = RST_TO_CYC2;
      default: to_cycles = RST_TO_CYC3;
    endcase
  endfunction : to_cycles

  function automatic logic uses_cmd_reg(input logic [3:0] ir);
    uses_cmd_reg = (ir == INSTR_CMD) || (ir == INSTR_PLOAD) || (ir == INSTR_PREAD);
  endfunction : uses_cmd_reg

  // ----------------------------------------------------------------
  // Engine state
  // ----------------------------------------------------------------
  logic [3:0] ir_r, ir_nxt, ir_sh_r, ir_sh_nxt;
  logic [14:0] cmd_sh_r, cmd_sh_nxt, cmd_r, cmd_nxt, result_r, result_nxt;
  logic [15:0] en_sh_r, en_sh_nxt, word_addr_r, word_addr_nxt, to_cnt_r, to_cnt_nxt;
  logic [15:0] wr_data_r, wr_data_nxt;
  logic [7:0] data_lo_r, data_lo_nxt, data_hi_r, data_hi_nxt;
  logic [1:0] wr_be_r, wr_be_nxt;
  logic rst_sh_r, rst_sh_nxt, byp_r, byp_nxt, prog_mode_r, prog_mode_nxt;
  logic exec_r, exec_nxt, rti_seen_r, rti_seen_nxt, wr_pend_r, wr_pend_nxt;
  logic pl_hi_r, pl_hi_nxt, pl_first_r, pl_first_nxt, pr_hi_r, pr_hi_nxt;
  logic part_reset_r, part_reset_nxt, tdo_r, tdo_nxt, tdo_oe_r, tdo_oe_nxt;

  always_comb begin
    ir_nxt = ir_r;
    ir_sh_nxt = ir_sh_r;
    cmd_sh_nxt = cmd_sh_r;
    cmd_nxt = cmd_r;
    result_nxt = result_r;
    en_sh_nxt = en_sh_r;
    word_addr_nxt = word_addr_r;
    to_cnt_nxt = to_cnt_r;
    wr_data_nxt = wr_data_r;
    data_lo_nxt = data_lo_r;
    data_hi_nxt = data_hi_r;
    wr_be_nxt = wr_be_r;
    rst_sh_nxt = rst_sh_r;
    byp_nxt = byp_r;
    prog_mode_nxt = prog_mode_r;
    pl_hi_nxt = pl_hi_r;
    pl_first_nxt = pl_first_r;
    pr_hi_nxt = pr_hi_r;
    tdo_nxt = tdo_r;
    tdo_oe_nxt = tdo_oe_r;
    exec_nxt = 1'b0;
    wr_pend_nxt = 1'b0;
    rti_seen_nxt = (tap_st == TAP_RTI);
    if (tck_rise) begin
      case (tap_st)
        TAP_TLR: ir_nxt = INSTR_BYPASS;
        TAP_CAP_IR: ir_sh_nxt = IR_CAPTURE;
        TAP_SH_IR: ir_sh_nxt = {tdi_s2_r, ir_sh_r[3:1]};
        TAP_UP_IR: begin
          ir_nxt = ir_sh_r;
          pl_hi_nxt = 1'b0;
          pl_first_nxt = 1'b1;
          pr_hi_nxt = 1'b0;
        end
        TAP_CAP_DR: begin
          byp_nxt = 1'b0;
          if (ir_r == INSTR_CMD) begin
            cmd_sh_nxt = result_r;
            cmd_sh_nxt[STATUS_BIT] = nvm_ready_i;
          end else if (ir_r == INSTR_PREAD && prog_mode_r) begin
            cmd_sh_nxt[7:0] = pr_hi_r ? mem_if.rdata[15:8] : mem_if.rdata[7:0];
            pr_hi_nxt = ~pr_hi_r;
            if (pr_hi_r) begin
              word_addr_nxt = word_addr_r + 16'h0001;
            end
          end
        end
        TAP_SH_DR: begin
          case (ir_r)
            INSTR_RESET: rst_sh_nxt = tdi_s2_r;
            INSTR_ENABLE: en_sh_nxt = {tdi_s2_r, en_sh_r[15:1]};
            INSTR_CMD: cmd_sh_nxt = {tdi_s2_r, cmd_sh_r[14:1]};
            INSTR_PLOAD, INSTR_PREAD: cmd_sh_nxt[7:0] = {tdi_s2_r, cmd_sh_r[7:1]};
            default: byp_nxt = tdi_s2_r;
          endcase
        end
        TAP_UP_DR: begin
          case (ir_r)
            INSTR_ENABLE: prog_mode_nxt = (en_sh_r == UNLOCK_SIG);
            INSTR_CMD: begin
              if (prog_mode_r) begin
                cmd_nxt = cmd_sh_r;
              end
            end
            INSTR_PLOAD: begin
              if (prog_mode_r) begin
                wr_data_nxt = {cmd_sh_r[7:0], cmd_sh_r[7:0]};
                wr_be_nxt = pl_hi_r ? 2'b10 : 2'b01;
                wr_pend_nxt = 1'b1;
                pl_hi_nxt = ~pl_hi_r;
                pl_first_nxt = 1'b0;
                if (!pl_hi_r && !pl_first_r) begin
                  word_addr_nxt = word_addr_r + 16'h0001;
                end
              end
            end
            default: ;
          endcase
        end
        default: ;
      endcase
    end
    // TDO moves on the falling test clock so the programmer samples a settled bit
    if (tck_fall) begin
      tdo_oe_nxt = (tap_st == TAP_SH_DR) || (tap_st == TAP_SH_IR);
      if (tap_st == TAP_SH_IR) begin
        tdo_nxt = ir_sh_r[0];
      end else if (uses_cmd_reg(ir_r)) begin
        tdo_nxt = cmd_sh_r[0];
      end else if (ir_r == INSTR_ENABLE) begin
        tdo_nxt = en_sh_r[0];
      end else if (ir_r == INSTR_RESET) begin
        tdo_nxt = rst_sh_r;
      end else begin
        tdo_nxt = byp_r;
      end
    end
    if (tap_st == TAP_RTI && !rti_seen_r && ir_r == INSTR_CMD && prog_mode_r) begin
      exec_nxt = 1'b1;
    end
    // Execute the applied command in its single internal clock
    if (exec_r) begin
      case (cmd_r[14:8])
        PFX_ADDR_LO: word_addr_nxt[7:0] = cmd_r[7:0];
        PFX_ADDR_HI: word_addr_nxt[15:8] = cmd_r[7:0];
        PFX_DATA_LO: data_lo_nxt = cmd_r[7:0];
        PFX_DATA_HI: data_hi_nxt = cmd_r[7:0];
        PFX_RD_LO: result_nxt = {7'h00, mem_if.rdata[7:0]};
        PFX_RD_HI: result_nxt = {7'h00, mem_if.rdata[15:8]};
        PFX_LATCH: begin
          wr_data_nxt = {data_hi_r, data_lo_r};
          wr_be_nxt = 2'b11;
          wr_pend_nxt = 1'b1;
        end
        default: ;
      endcase
    end
    if (rst_sh_r && !rst_sh_nxt) begin
      to_cnt_nxt = to_cycles(cksel_i);
    end else if (to_cnt_r != 16'h0000) begin
      to_cnt_nxt = to_cnt_r - 16'h0001;
    end
    part_reset_nxt = rst_sh_nxt || (to_cnt_nxt != 16'h0000);
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ir_r <= INSTR_BYPASS;
      ir_sh_r <= 4'h0;
      {cmd_sh_r, cmd_r, result_r} <= {3{15'h0000}};
      en_sh_r <= EN_RESET;
      {word_addr_r, to_cnt_r, wr_data_r} <= {3{16'h0000}};
      {data_lo_r, data_hi_r} <= 16'h0000;
      wr_be_r <= 2'h0;
      {rst_sh_r, byp_r, prog_mode_r, exec_r, rti_seen_r, wr_pend_r} <= 6'h00;
      {pl_hi_r, pl_first_r, pr_hi_r} <= 3'h2;
      {part_reset_r, tdo_r, tdo_oe_r} <= 3'h0;
    end else begin
      ir_r <= ir_nxt;
      ir_sh_r <= ir_sh_nxt;
      {cmd_sh_r, cmd_r, result_r} <= {cmd_sh_nxt, cmd_nxt, result_nxt};
      en_sh_r <= en_sh_nxt;
      {word_addr_r, to_cnt_r, wr_data_r} <= {word_addr_nxt, to_cnt_nxt, wr_data_nxt};
      {data_lo_r, data_hi_r} <= {data_lo_nxt, data_hi_nxt};
      wr_be_r <= wr_be_nxt;
      {rst_sh_r, byp_r, prog_mode_r} <= {rst_sh_nxt, byp_nxt, prog_mode_nxt};
      {exec_r, rti_seen_r, wr_pend_r} <= {exec_nxt, rti_seen_nxt, wr_pend_nxt};
      {pl_hi_r, pl_first_r, pr_hi_r} <= {pl_hi_nxt, pl_first_nxt, pr_hi_nxt};
      {part_reset_r, tdo_r, tdo_oe_r} <= {part_reset_nxt, tdo_nxt, tdo_oe_nxt};
    end
  end

  // ----------------------------------------------------------------
  // Page buffer port and outputs
  // ----------------------------------------------------------------
  // Address wraps inside the page buffer; bits above the low six never reach the array
  assign mem_if.we = wr_pend_r;
  assign mem_if.be = wr_be_r;
  assign mem_if.addr = word_addr_r[PAGE_AW-1:0];
  assign mem_if.wdata = wr_data_r;

  assign tdo_o = tdo_r;
  assign tdo_oe_o = tdo_oe_r;
  assign part_reset_o = part_reset_r;
  assign prog_enabled_o = prog_mode_r;
  assign nvm_cmd_o = cmd_r;
  assign nvm_exec_o = exec_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  sequence s_dr_step(jnp_tap_t st, logic [3:0] ins);
    tck_rise && tap_st == st && ir_r == ins;
  endsequence

  sequence s_pl_update;
    s_dr_step(TAP_UP_DR, INSTR_PLOAD) ##0 prog_mode_r;
  endsequence

  cmd_shift_a: assert property (s_dr_step(TAP_SH_DR, INSTR_CMD) |=>
    cmd_sh_r == {$past(tdi_s2_r), $past(cmd_sh_r[14:1])}) else $error("command shift wrong");
  cmd_capture_a: assert property (s_dr_step(TAP_CAP_DR, INSTR_CMD) |=>
    cmd_sh_r[8:0] == $past(result_r[8:0])) else $error("command capture wrong");
  cmd_apply_a: assert property (s_dr_step(TAP_UP_DR, INSTR_CMD) ##0 prog_mode_r |=>
    nvm_cmd_o == $past(cmd_sh_r)) else $error("command not applied");
  exec_once_a: assert property (nvm_exec_o |=> !nvm_exec_o [*8])
    else $error("execute clock repeated");
  pl_write_a: assert property (s_pl_update |-> ##[1:3] mem_if.we)
    else $error("page byte not written");
  pl_alt_a: assert property (s_pl_update |=> pl_hi_r != $past(pl_hi_r))
    else $error("page byte order wrong");
  pr_inc_a: assert property (s_dr_step(TAP_CAP_DR, INSTR_PREAD) ##0 prog_mode_r && pr_hi_r
    |=> word_addr_r == $past(word_addr_r) + 16'h0001) else $error("read address not advanced");
  unlock_a: assert property (s_dr_step(TAP_UP_DR, INSTR_ENABLE) |=>
    prog_enabled_o == ($past(en_sh_r) == UNLOCK_SIG)) else $error("unlock compare wrong");
  rst_hold_a: assert property (rst_sh_r |-> part_reset_o)
    else $error("reset bit not driving reset");
  rst_timeout_a: assert property ($fell(rst_sh_r) |-> part_reset_o [*3])
    else $error("reset released before time-out");
endmodule : jnp_top

// file: verification/jnp_prog_model.sv
// Behavioural external programmer that drives the test-port pins
`timescale 1ns/10ps
module jnp_prog_model (
  input wire logic clk_sys_i,
  input wire logic tdo_i,
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o
);
  import jnp_pkg::*;
  initial begin
    tck_o = 1'b1;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end
  // --------------------------------------------------------------
  // Pin sequencing
  // --------------------------------------------------------------
  // Low 5 clk, high 3 clk: TDO has settled well before the rise
  task automatic tick(input logic ms, input logic di, output logic do_bit);
    @(negedge clk_sys_i);
    tck_o = 1'b0;
    tms_o = ms;
    tdi_o = di;
    repeat (5) @(negedge clk_sys_i);
    do_bit = tdo_i;
    tck_o = 1'b1;
    repeat (2) @(negedge clk_sys_i);
  endtask : tick
  task automatic walk(input logic [7:0] ms, input int n);
    logic d;
    for (int i = 0; i < n; i++) tick(ms[i], tdi_o, d);
  endtask : walk
  task automatic tap_reset();
    walk(8'h1F, 6);
  endtask : tap_reset
  // From idle, scan n bits and come back to idle with one spare clock
  task automatic scan(input logic ir, input int n, input logic [15:0] din,
      output logic [15:0] dout);
    logic d;
    dout = '0;
    walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], d);
      dout[i] = d;
    end
    walk(8'h01, 3);
    // Clock stands still between frames, so TDI must not look held
    tdi_o = ~tdi_o;
  endtask : scan
  task automatic poll(input logic [14:0] cmd, output int tries);
    logic [15:0] r;
    tries = 0;
    do begin
      scan(1'b0, CMD_W, {1'b0, cmd}, r);
      tries++;
    end while (r[STATUS_BIT] !== 1'b1 && tries < 50);
  endtask : poll
endmodule : jnp_prog_model

// file: verification/jnp_top_tb.sv
// Self-checking bench for the test-port programming engine
`timescale 1ns/10ps
`define JNP_CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module jnp_top_tb;
  import jnp_pkg::*;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic nvm_ready_i = 1'b0;
  logic [1:0] cksel_i = 2'h0;
  logic tck, tms, tdi, tdo, tdo_oe, part_rst, prog_en, exec;
  logic [14:0] nvm_cmd;
  logic [15:0] r;
  int n_mismatch = 0;
  int check_count = 0;
  int exec_cnt = 0;

  always #12.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (exec === 1'b1) exec_cnt <= exec_cnt + 1;

  jnp_top DUT (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .tck_i(tck), .tms_i(tms),
    .tdi_i(tdi), .nvm_ready_i(nvm_ready_i), .cksel_i(cksel_i), .tdo_o(tdo),
    .tdo_oe_o(tdo_oe), .part_reset_o(part_rst), .prog_enabled_o(prog_en),
    .nvm_cmd_o(nvm_cmd), .nvm_exec_o(exec));
  jnp_prog_model PRG (.clk_sys_i(clk_sys_i), .tdo_i(tdo), .tck_o(tck), .tms_o(tms),
    .tdi_o(tdi));

  // ----------------------------------------------------------------
  // Shared scan helpers
  // ----------------------------------------------------------------
  task automatic ir(input logic [3:0] code);
    PRG.scan(1'b1, 4, {12'h000, code}, r);
  endtask : ir
  task automatic cmd(input logic [14:0] w);
    PRG.scan(1'b0, CMD_W, {1'b0, w}, r);
  endtask : cmd

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_unlock();
    ir(INSTR_BYPASS);
    PRG.scan(1'b0, 2, 16'h0001, r);
    `JNP_CHK(r[1:0], 2'h2)
    ir(INSTR_RESET);
    `JNP_CHK(r[3:0], IR_CAPTURE)
    `JNP_CHK(tdo_oe, 1'b0)
    PRG.scan(1'b0, 1, 16'h0001, r);
    `JNP_CHK(part_rst, 1'b1)
    ir(INSTR_CMD);
    cmd(15'h0305);
    `JNP_CHK(nvm_cmd, 15'h0000)
    ir(INSTR_ENABLE);
    PRG.scan(1'b0, EN_W, 16'hA371, r);
    `JNP_CHK(prog_en, 1'b0)
    PRG.scan(1'b0, EN_W, UNLOCK_SIG, r);
    `JNP_CHK(prog_en, 1'b1)
  endtask : test_unlock

  task automatic test_command();
    logic [14:0] er [4] = '{15'h2380, 15'h3180, 15'h3380, 15'h3380};
    logic [14:0] wr [13] = '{15'h2310, 15'h0B00, 15'h0700, 15'h0305, 15'h13A5, 15'h17C3,
      15'h3700, 15'h7700, 15'h3700, 15'h3700, 15'h3500, 15'h3700, 15'h3700};
    logic [14:0] rd [5] = '{15'h2302, 15'h0B00, 15'h0700, 15'h0305, 15'h3200};
    int e0;
    int tries;
    ir(INSTR_CMD);
    e0 = exec_cnt;
    for (int i = 0; i < 4; i++) begin
      cmd(er[i]);
      `JNP_CHK(nvm_cmd, er[i])
      `JNP_CHK(exec_cnt, e0 + i + 1)
    end
    `JNP_CHK(r[STATUS_BIT], 1'b0)
    nvm_ready_i = 1'b1;
    PRG.poll(15'h3380, tries);
    `JNP_CHK(tries, 1)
    foreach (wr[i]) cmd(wr[i]);
    PRG.poll(15'h3700, tries);
    foreach (rd[i]) cmd(rd[i]);
    cmd(15'h3600);
    `JNP_CHK(r[7:0], 8'hA5)
    cmd(15'h3700);
    `JNP_CHK(r[7:0], 8'hC3)
  endtask : test_command

  task automatic test_eeprom();
    logic [14:0] ew [7] = '{15'h2311, 15'h0700, 15'h030A, 15'h133C, 15'h3700, 15'h7700,
      15'h3700};
    foreach (ew[i]) cmd(ew[i]);
    cmd(15'h2302);
    cmd(15'h3200);
    cmd(15'h3600);
    `JNP_CHK(r[7:0], 8'h3C)
  endtask : test_eeprom

  task automatic test_page();
    logic [7:0] pl [4] = '{8'h5A, 8'h96, 8'h0F, 8'hE1};
    cmd(15'h0308);
    ir(INSTR_PLOAD);
    foreach (pl[i]) PRG.scan(1'b0, 8, {8'h00, pl[i]}, r);
    ir(INSTR_CMD);
    cmd(15'h0309);
    cmd(15'h3200);
    cmd(15'h3600);
    `JNP_CHK(r[7:0], pl[2])
    cmd(15'h3700);
    `JNP_CHK(r[7:0], pl[3])
    cmd(15'h0308);
    ir(INSTR_PREAD);
    for (int i = 0; i < 4; i++) begin
      PRG.scan(1'b0, 8, 16'h0000, r);
      `JNP_CHK(r[7:0], pl[i])
    end
  endtask : test_page

  task automatic test_reset_timing();
    int tmo [4] = '{4, 64, 256, 1024};
    int n;
    resetn_i = 1'b0;
    repeat (8) @(negedge clk_sys_i);
    `JNP_CHK({prog_en, nvm_cmd}, 16'h0000)
    resetn_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    PRG.tap_reset();
    ir(INSTR_RESET);
    for (int k = 0; k < 4; k++) begin
      cksel_i = 2'(k);
      PRG.scan(1'b0, 1, 16'h0001, r);
      `JNP_CHK(part_rst, 1'b1)
      PRG.scan(1'b0, 1, 16'h0000, r);
      n = 0;
      while (part_rst === 1'b1 && n < 2000) begin
        @(negedge clk_sys_i);
        n++;
      end
      // Scan tail after the bit clears is under 40 clk
      `JNP_CHK((n <= tmo[k]) && (n + 40 >= tmo[k]), 1'b1)
    end
  endtask : test_reset_timing

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude

  initial begin
    repeat (8) @(negedge clk_sys_i);
    resetn_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    `JNP_CHK({part_rst, prog_en, nvm_cmd}, 17'h00000)
    PRG.tap_reset();
    test_unlock();
    test_command();
    test_eeprom();
    test_page();
    test_reset_timing();
    conclude();
  end

  // About 70 scans of under 200 clk plus 1.4k clk of time-outs
  initial begin
    repeat (40000) @(negedge clk_sys_i);
    n_mismatch++;
    conclude();
  end
endmodule : jnp_top_tb
